// ---- design/exlp_pkg.sv ----
// Package of constants for the exception and low-power control block.
// Assumes an AHB-Lite register bus with 32-bit data, one word per register.
package exlp_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] BREAK_STATUS_OFS = 8'h00;
   localparam logic [7:0] RESET_SOURCE_OFS = 8'h04;
   localparam logic [7:0] BREAK_FLAG_CTRL_OFS = 8'h08;
   localparam logic [7:0] CONFIG_OFS = 8'h0c;
   // ==========================================================
   // Field positions
   localparam int BREAK_WAIT_BIT = 1;
   localparam int FLAG_CLR_EN_BIT = 7;
   localparam int SHORT_REC_BIT = 0;
   localparam int WDOG_DIS_BIT = 1;
   localparam int RS_POR_BIT = 7;
   localparam int RS_PIN_BIT = 6;
   localparam int RS_WDOG_BIT = 5;
   localparam int RS_OPC_BIT = 4;
   localparam int RS_ADR_BIT = 3;
   localparam int RS_LV_BIT = 1;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RESET_SOURCE_RST = 8'h80;
   localparam logic [7:0] BREAK_FLAG_CTRL_RST = 8'h00;
   localparam logic [7:0] CONFIG_RST = 8'h00;
   // ==========================================================
   // Timing counts, in hclk cycles
   localparam int STOP_LONG_CYC = 4096;
   localparam int STOP_SHORT_CYC = 32;
   // ==========================================================
   // Vector selection codes handed to the CPU, and sequencer state encoding
   typedef enum logic [1:0] {
      EXLP_VEC_NONE = 2'b00,
      EXLP_VEC_HW = 2'b01,
      EXLP_VEC_SOFT = 2'b10
   } exlp_vec_t;
   typedef enum logic [2:0] {
      EXLP_RUN = 3'b000,
      EXLP_STACK = 3'b001,
      EXLP_SERVICE = 3'b010,
      EXLP_WAIT = 3'b011,
      EXLP_STOP = 3'b100,
      EXLP_RECOVER = 3'b101
   } exlp_state_t;
endpackage

// ---- design/exlp_sync.sv ----
// Two-flop synchroniser for a bus of asynchronous levels.
// Assumes hclk domain and asynchronous active-low reset.
`timescale 1ns/1ps
module exlp_sync #(
   parameter int W = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } exlp_sync_st_t;
   exlp_sync_st_t st_q, st_d;
   always_comb begin
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign q = st_q.s2;
endmodule

// ---- design/exlp_core.sv ----
// Exception and low-power control: interrupt latch and arbitration, software
// interrupt and break entry, wait/stop sequencing with stop recovery timing,
// break flag protection, break status and reset source registers.
// Assumes an AHB-Lite master on hclk; CPU handshakes are synchronous to hclk,
// wake and reset-cause pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
// Overview of operation
// - On entry request stacking and set the mask; return restores the stack.
// - Latch and arbitrate requests at entry, giving the CPU a vector code.
// - Once latched, nothing overtakes until serviced or mask cleared.
// - Hardware interrupts wait for the current instruction to finish.
// - At instruction end, take only unmasked, enabled pending requests.
// - Several pending at once: the highest priority goes first.
// - Request pending at return is taken before the next instruction.
// - Entry stacking leaves out the index high register.
// - Software interrupt is taken whatever the mask state.
// - Software interrupt stacks PC; hardware interrupt stacks PC minus one.
// - Reset outranks every interrupt and is never arbitrated.
// - Break output forces the CPU to the software interrupt vector.
// - In break, other flags stay protected unless clear enable set.
// - Two-step clears stay protected through break; second step after clears. Here second_step_allow just follows flag_clear_allow; step_held is unused.
// - Wait or stop clears the mask, enters low power, stops CPU clock.
// - Wait stops CPU clock only; enabled interrupt wakes, stacks next cycle.
// - Reset or break also leaves wait; break sets the break wait flag.
// - With watchdog disable at 0, watchdog keeps running in wait.
// - Stop gates CPU, peripheral and oscillator clocks; counter held, then times recovery before stacking.
// - Recovery is 4096 cycles, or 32 with short stop recovery set.
// - Break wait flag clears on software writing 0 and on reset.
// - Reading reset source clears it; power-on sets only its own flag.
// - Each reset source flag marks the last cause; power-on or read clears.
module exlp_core #(
   parameter int N_IRQ = 8,
   parameter int STOP_LONG = exlp_pkg::STOP_LONG_CYC,
   parameter int STOP_SHORT = exlp_pkg::STOP_SHORT_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [N_IRQ-1:0] irq_req,
   input wire logic [N_IRQ-1:0] irq_en,
   input wire logic cpu_mask,
   input wire logic instr_end,
   input wire logic soft_int_exec,
   input wire logic wait_exec,
   input wire logic stop_exec,
   input wire logic int_return_exec,
   input wire logic break_req,
   input wire logic por_rst,
   input wire logic [4:0] rst_cause,
   input wire logic two_step_armed,
   output logic stack_req,
   output logic stack_pc_minus1,
   output logic stack_index_high,
   output logic set_mask,
   output logic clear_mask,
   output logic [1:0] vec_sel,
   output logic [N_IRQ-1:0] irq_ack,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic osc_clk_en,
   output logic wdog_run,
   output logic break_mode,
   output logic flag_clear_allow,
   output logic second_step_allow
);
   // ==========================================================
   // Parameter checks
   initial begin
      if (N_IRQ < 1 || N_IRQ > 16 || STOP_SHORT < 1 || STOP_LONG <= STOP_SHORT || STOP_LONG > 65535) begin
         $error("exlp_core: unsupported parameter values");
      end
   end

   // ==========================================================
   // Synchronise asynchronous inputs (wake requests, break, reset causes)
   localparam int SW = N_IRQ + 7;
   logic [SW-1:0] sync_in, sync_out;
   assign sync_in = {irq_req, break_req, por_rst, rst_cause};
   exlp_sync #(.W(SW)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d(sync_in),
      .q(sync_out)
   );
   logic [N_IRQ-1:0] irq_s;
   logic brk_s, por_s;
   logic [4:0] cause_s;
   assign irq_s = sync_out[SW-1:7];
   assign brk_s = sync_out[6];
   assign por_s = sync_out[5];
   assign cause_s = sync_out[4:0];

   // ==========================================================
   // State
   typedef struct packed {
      exlp_pkg::exlp_state_t fsm;
      logic [N_IRQ-1:0] latched;
      logic [1:0] vec;
      logic pcm1;
      logic stack;
      logic setm;
      logic clrm;
      logic [N_IRQ-1:0] ack;
      logic cpu_en;
      logic per_en;
      logic osc_en;
      logic wdog;
      logic brk;
      logic clr_ok;
      logic step2_ok;
      logic step_held;
      logic [15:0] cnt;
      logic break_wait_flag;
      logic [7:0] rsrc;
      logic [7:0] ctrl;
      logic [7:0] cfg;
      logic dp_act;
      logic dp_wr;
      logic [7:0] dp_addr;
      logic [31:0] rdata;
      logic por_seen;
      logic [4:0] cause_seen;
   } exlp_st_t;
   exlp_st_t s_q, s_d;

   // Highest priority = lowest index among enabled pending requests
   logic [N_IRQ-1:0] cand, pick;
   logic any_hw;
   always_comb begin
      cand = irq_s & irq_en;
      pick = '0;
      any_hw = 1'b0;
      for (int i = N_IRQ - 1; i >= 0; i--) begin
         if (cand[i]) begin
            pick = '0;
            pick[i] = 1'b1;
            any_hw = 1'b1;
         end
      end
   end

   logic addr_ph, rd_hit;
   logic [15:0] recov_len;
   assign addr_ph = hsel && htrans[1] && hready;
   assign rd_hit = s_q.dp_act && !s_q.dp_wr && s_q.dp_addr == exlp_pkg::RESET_SOURCE_OFS;
   assign recov_len = s_q.cfg[exlp_pkg::SHORT_REC_BIT] ? 16'(STOP_SHORT) : 16'(STOP_LONG);

   always_comb begin
      s_d = s_q;
      s_d.stack = 1'b0;
      s_d.setm = 1'b0;
      s_d.clrm = 1'b0;
      s_d.ack = '0;
      // ==========================================================
      // AHB-Lite slave: zero wait states, OKAY always
      s_d.dp_act = addr_ph;
      s_d.dp_wr = hwrite;
      s_d.dp_addr = haddr[7:0];
      if (addr_ph && !hwrite) begin
         unique case (haddr[7:0])
            exlp_pkg::BREAK_STATUS_OFS: s_d.rdata = {30'h0, s_q.break_wait_flag, 1'b0};
            exlp_pkg::RESET_SOURCE_OFS: s_d.rdata = {24'h0, s_q.rsrc};
            exlp_pkg::BREAK_FLAG_CTRL_OFS: s_d.rdata = {24'h0, s_q.ctrl};
            exlp_pkg::CONFIG_OFS: s_d.rdata = {24'h0, s_q.cfg};
            default: s_d.rdata = 32'h0;
         endcase
      end
      if (rd_hit) begin
         s_d.rsrc = 8'h00;
      end
      if (s_q.dp_act && s_q.dp_wr) begin
         unique case (s_q.dp_addr)
            exlp_pkg::BREAK_STATUS_OFS: begin
               if (!hwdata[exlp_pkg::BREAK_WAIT_BIT]) begin
                  s_d.break_wait_flag = 1'b0;
               end
            end
            exlp_pkg::BREAK_FLAG_CTRL_OFS: s_d.ctrl = {hwdata[7], 7'h0};
            exlp_pkg::CONFIG_OFS: s_d.cfg = {6'h0, hwdata[1:0]};
            default: ;
         endcase
      end
      // ==========================================================
      // Reset source capture on rising cause (last cause wins)
      s_d.por_seen = por_s;
      s_d.cause_seen = cause_s;
      if (|(cause_s & ~s_q.cause_seen)) begin
         s_d.rsrc = {1'b0, cause_s[4], cause_s[3], cause_s[2], cause_s[1], 1'b0, cause_s[0], 1'b0};
      end
      if (por_s && !s_q.por_seen) begin
         s_d.rsrc = exlp_pkg::RESET_SOURCE_RST;
      end
      // ==========================================================
      // Break flag protection
      // protect unless clear enable
      s_d.clr_ok = !s_q.brk || s_q.ctrl[exlp_pkg::FLAG_CLR_EN_BIT];
      if (s_q.brk && two_step_armed) begin
         s_d.step_held = 1'b1;
      end else if (!two_step_armed) begin
         s_d.step_held = 1'b0;
      end
      s_d.step2_ok = s_d.clr_ok;
      s_d.wdog = !s_q.cfg[exlp_pkg::WDOG_DIS_BIT] && s_q.fsm != exlp_pkg::EXLP_STOP
                 && s_q.fsm != exlp_pkg::EXLP_RECOVER;
      // ==========================================================
      // Exception and low-power sequencer
      unique case (s_q.fsm)
         exlp_pkg::EXLP_RUN: begin
            s_d.cpu_en = 1'b1;
            s_d.per_en = 1'b1;
            s_d.osc_en = 1'b1;
            if (brk_s && !s_q.brk) begin
               s_d.brk = 1'b1;
               s_d.vec = exlp_pkg::EXLP_VEC_SOFT;
               s_d.pcm1 = 1'b1;
               s_d.fsm = exlp_pkg::EXLP_STACK;
            end else if (soft_int_exec) begin
               s_d.vec = exlp_pkg::EXLP_VEC_SOFT;
               s_d.pcm1 = 1'b0;
               s_d.fsm = exlp_pkg::EXLP_STACK;
            end else if (wait_exec || stop_exec) begin
               s_d.clrm = 1'b1;
               s_d.cpu_en = 1'b0;
               if (stop_exec) begin
                  s_d.per_en = 1'b0;
                  s_d.osc_en = 1'b0;
                  s_d.cnt = '0;
                  s_d.fsm = exlp_pkg::EXLP_STOP;
               end else begin
                  s_d.fsm = exlp_pkg::EXLP_WAIT;
               end
            end else if (instr_end && !cpu_mask && any_hw) begin
               s_d.latched = pick;
               s_d.vec = exlp_pkg::EXLP_VEC_HW;
               s_d.pcm1 = 1'b1;
               s_d.fsm = exlp_pkg::EXLP_STACK;
            end
            if (!brk_s) begin
               s_d.brk = 1'b0;
            end
         end
         exlp_pkg::EXLP_STACK: begin
            s_d.stack = 1'b1;
            s_d.setm = 1'b1;
            s_d.cpu_en = 1'b1;
            s_d.per_en = 1'b1;
            s_d.osc_en = 1'b1;
            s_d.ack = s_q.latched;
            s_d.fsm = exlp_pkg::EXLP_SERVICE;
         end
         exlp_pkg::EXLP_SERVICE: begin
            if (int_return_exec) begin
               s_d.latched = '0;
               s_d.vec = exlp_pkg::EXLP_VEC_NONE;
               if (!brk_s) begin
                  s_d.brk = 1'b0;
               end
               if (any_hw && !cpu_mask) begin
                  s_d.latched = pick;
                  s_d.vec = exlp_pkg::EXLP_VEC_HW;
                  s_d.pcm1 = 1'b1;
                  s_d.fsm = exlp_pkg::EXLP_STACK;
               end else begin
                  s_d.fsm = exlp_pkg::EXLP_RUN;
               end
            end
         end
         exlp_pkg::EXLP_WAIT: begin
            if (brk_s) begin
               s_d.break_wait_flag = 1'b1;
               s_d.brk = 1'b1;
               s_d.vec = exlp_pkg::EXLP_VEC_SOFT;
               s_d.pcm1 = 1'b1;
               s_d.fsm = exlp_pkg::EXLP_STACK;
            end else if (any_hw) begin
               s_d.latched = pick;
               s_d.vec = exlp_pkg::EXLP_VEC_HW;
               s_d.pcm1 = 1'b1;
               s_d.fsm = exlp_pkg::EXLP_STACK;
            end
         end
         exlp_pkg::EXLP_STOP: begin
            s_d.cnt = '0;
            if (any_hw || brk_s) begin
               s_d.osc_en = 1'b1;
               s_d.fsm = exlp_pkg::EXLP_RECOVER;
            end
         end
         exlp_pkg::EXLP_RECOVER: begin
            s_d.cnt = s_q.cnt + 16'h0001;
            if (s_q.cnt == recov_len - 16'h0001) begin
               s_d.brk = brk_s;
               s_d.latched = brk_s ? '0 : pick;
               s_d.vec = brk_s ? exlp_pkg::EXLP_VEC_SOFT : exlp_pkg::EXLP_VEC_HW;
               s_d.pcm1 = 1'b1;
               s_d.fsm = exlp_pkg::EXLP_STACK;
            end
         end
         default: s_d.fsm = exlp_pkg::EXLP_RUN;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
         s_q.fsm <= exlp_pkg::EXLP_RUN;
         s_q.cpu_en <= 1'b1;
         s_q.per_en <= 1'b1;
         s_q.osc_en <= 1'b1;
         s_q.clr_ok <= 1'b1;
         s_q.step2_ok <= 1'b1;
         s_q.wdog <= 1'b1;
         s_q.rsrc <= exlp_pkg::RESET_SOURCE_RST;
         s_q.ctrl <= exlp_pkg::BREAK_FLAG_CTRL_RST;
         s_q.cfg <= exlp_pkg::CONFIG_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs straight from flops, except constant hreadyout, hresp and stack_index_high
   assign hrdata = s_q.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign stack_req = s_q.stack;
   assign stack_pc_minus1 = s_q.pcm1;
   assign stack_index_high = s_q.dp_act & 1'b0;
   assign set_mask = s_q.setm;
   assign clear_mask = s_q.clrm;
   assign vec_sel = s_q.vec;
   assign irq_ack = s_q.ack;
   assign cpu_clk_en = s_q.cpu_en;
   assign periph_clk_en = s_q.per_en;
   assign osc_clk_en = s_q.osc_en;
   assign wdog_run = s_q.wdog;
   assign break_mode = s_q.brk;
   assign flag_clear_allow = s_q.clr_ok;
   assign second_step_allow = s_q.step2_ok;
endmodule

// ---- verif/exlp_core_sva.sv ----
// Assertion checker for the exception and low-power control block.
// Assumes it is bound to exlp_core and sees only that module's ports.
`timescale 1ns/1ps
module exlp_core_sva #(
   parameter int N_IRQ = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [N_IRQ-1:0] irq_ack,
   input wire logic soft_int_exec,
   input wire logic wait_exec,
   input wire logic stop_exec,
   input wire logic int_return_exec,
   input wire logic break_req,
   input wire logic stack_req,
   input wire logic stack_pc_minus1,
   input wire logic stack_index_high,
   input wire logic set_mask,
   input wire logic clear_mask,
   input wire logic [1:0] vec_sel,
   input wire logic cpu_clk_en,
   input wire logic periph_clk_en,
   input wire logic osc_clk_en,
   input wire logic break_mode,
   input wire logic flag_clear_allow
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ==========================================================
   // Bus and entry
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus answer not zero-wait OKAY");
   entry_mask_a: assert property (stack_req |-> set_mask && vec_sel != exlp_pkg::EXLP_VEC_NONE)
      else $error("stacking without mask set or vector");
   no_index_a: assert property (stack_index_high == 1'b0)
      else $error("index high stacked");
   ack_stack_a: assert property (irq_ack != '0 |-> stack_req && $onehot(irq_ack) && stack_pc_minus1)
      else $error("acknowledge not one-hot with stacking of pc minus one");
   soft_entry_a: assert property (soft_int_exec && vec_sel == exlp_pkg::EXLP_VEC_NONE
      |-> ##2 stack_req && !stack_pc_minus1)
      else $error("software interrupt not stacked with pc");
   vec_hold_a: assert property (vec_sel != exlp_pkg::EXLP_VEC_NONE && !int_return_exec && !break_req
      |=> $stable(vec_sel))
      else $error("latched vector changed before return");
   break_vec_a: assert property ($rose(break_req) |-> ##[1:6] vec_sel == exlp_pkg::EXLP_VEC_SOFT)
      else $error("break did not force software vector");
   // ==========================================================
   // Low power and break protection
   wait_entry_a: assert property (wait_exec |=> clear_mask && !cpu_clk_en && periph_clk_en)
      else $error("wait entry clocks or mask wrong");
   stop_entry_a: assert property (stop_exec |=> clear_mask && !cpu_clk_en && !periph_clk_en && !osc_clk_en)
      else $error("stop entry clocks or mask wrong");
   flag_open_a: assert property (!break_mode && !$past(break_mode) |-> flag_clear_allow)
      else $error("flags protected outside break");
endmodule

// ---- verif/exlp_cpu_model.sv ----
// CPU core model: keeps the interrupt mask and returns from service.
// Assumes exlp_core pulses on hclk; svc_len sets the service length.
`timescale 1ns/1ps
module exlp_cpu_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic stack_req,
   input wire logic set_mask,
   input wire logic clear_mask,
   input wire logic hold_mask,
   input wire logic [7:0] svc_len,
   output logic cpu_mask,
   output logic int_return_exec
);
   logic mask_q;
   logic [8:0] cnt_q;
   assign cpu_mask = mask_q | hold_mask;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_q <= 1'b0;
         cnt_q <= 9'h000;
         int_return_exec <= 1'b0;
      end else begin
         int_return_exec <= 1'b0;
         if (set_mask) mask_q <= 1'b1;
         if (clear_mask) mask_q <= 1'b0;
         if (stack_req) begin
            cnt_q <= {1'b0, svc_len} + 9'h001;
         end else if (cnt_q == 9'h001) begin
            int_return_exec <= 1'b1;
            mask_q <= 1'b0;
            cnt_q <= 9'h000;
         end else if (cnt_q != 9'h000) begin
            cnt_q <= cnt_q - 9'h001;
         end
      end
   end
endmodule

// ---- verif/exlp_core_tb.sv ----
// Testbench for exlp_core: AHB-Lite tasks, CPU model, peripheral requests.
// Assumes the design files and exlp_cpu_model are compiled first.
`timescale 1ns/1ps
module exlp_core_tb;
   localparam int N_IRQ = 8;
   localparam int LONG = 64;
   localparam int SHORT = 32;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, cpu_mask, int_return_exec, hold_mask = 1'b0, last_pc;
   logic [N_IRQ-1:0] irq_req = '0, irq_en = '1, irq_ack, acks = '0;
   logic instr_end = 1'b0, soft_int_exec = 1'b0, wait_exec = 1'b0, stop_exec = 1'b0;
   logic break_req = 1'b0, por_rst = 1'b0, two_step_armed = 1'b0;
   logic [4:0] rst_cause = 5'h00;
   logic [7:0] svc_len = 8'h03;
   logic stack_req, stack_pc_minus1, stack_index_high, set_mask, clear_mask;
   logic cpu_clk_en, periph_clk_en, osc_clk_en, wdog_run, break_mode, flag_clear_allow, second_step_allow;
   logic [1:0] vec_sel;
   int n_mismatch = 0, num_checks = 0, n_stack = 0, s0, n;
   int pos [5] = '{exlp_pkg::RS_LV_BIT, exlp_pkg::RS_ADR_BIT, exlp_pkg::RS_OPC_BIT,
                   exlp_pkg::RS_WDOG_BIT, exlp_pkg::RS_PIN_BIT};
   always #20 hclk = ~hclk;
   exlp_core #(.N_IRQ(N_IRQ), .STOP_LONG(LONG), .STOP_SHORT(SHORT)) i_exlp_core (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .irq_req(irq_req), .irq_en(irq_en), .cpu_mask(cpu_mask), .instr_end(instr_end),
      .soft_int_exec(soft_int_exec), .wait_exec(wait_exec), .stop_exec(stop_exec),
      .int_return_exec(int_return_exec), .break_req(break_req),
      .por_rst(por_rst), .rst_cause(rst_cause), .two_step_armed(two_step_armed), .stack_req(stack_req),
      .stack_pc_minus1(stack_pc_minus1), .stack_index_high(stack_index_high), .set_mask(set_mask),
      .clear_mask(clear_mask), .vec_sel(vec_sel), .irq_ack(irq_ack), .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en), .osc_clk_en(osc_clk_en), .wdog_run(wdog_run), .break_mode(break_mode),
      .flag_clear_allow(flag_clear_allow), .second_step_allow(second_step_allow));
   exlp_cpu_model i_exlp_cpu_model (.hclk(hclk), .hresetn(hresetn), .stack_req(stack_req),
      .set_mask(set_mask), .clear_mask(clear_mask), .hold_mask(hold_mask), .svc_len(svc_len),
      .cpu_mask(cpu_mask), .int_return_exec(int_return_exec));
   // ==========================================================
   // Peripheral side: a request drops once acknowledged
   always @(posedge hclk) begin
      if (stack_req === 1'b1) begin
         n_stack++;
         acks <= acks | irq_ack;
         last_pc <= stack_pc_minus1;
         irq_req <= irq_req & ~irq_ack;
      end
   end
   // ==========================================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= 3'b010;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(x, exp, msg);
   endtask
   // Pulse order {soft, wait, stop, instr_end}
   task automatic step(input logic [3:0] p);
      @(posedge hclk);
      {soft_int_exec, wait_exec, stop_exec, instr_end} <= p;
      @(posedge hclk);
      {soft_int_exec, wait_exec, stop_exec, instr_end} <= 4'h0;
   endtask
   task automatic end_of_test();
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge hclk);
      n_mismatch++;
      end_of_test();
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      rd_chk(8'h04, 32'h80, "reset source after reset");
      rd_chk(8'h04, 32'h00, "reset source read clear");
      rd_chk(8'h00, 32'h00, "break status reset");
      rd_chk(8'h08, 32'h00, "break flag ctrl reset");
      wr(8'h20, 32'hffffffff);
      rd_chk(8'h20, 32'h00, "unmapped read");
      wr(8'h0c, 32'h03);
      rd_chk(8'h0c, 32'h03, "config readback");
      wr(8'h0c, 32'h00);
      for (int k = 0; k < 5; k++) begin
         rst_cause <= 5'h01 << k;
         repeat (4) @(posedge hclk);
         rst_cause <= 5'h00;
         repeat (4) @(posedge hclk);
         rd_chk(8'h04, 32'h1 << pos[k], "reset cause flag");
      end
      rst_cause <= 5'h01;
      repeat (4) @(posedge hclk);
      rst_cause <= 5'h00;
      por_rst <= 1'b1;
      repeat (4) @(posedge hclk);
      por_rst <= 1'b0;
      repeat (4) @(posedge hclk);
      rd_chk(8'h04, 32'h80, "power-on only flag");
      s0 = n_stack;
      irq_req <= 8'h24;
      repeat (4) @(posedge hclk);
      step(4'h1);
      repeat (8) @(posedge hclk);
      step(4'h1);
      repeat (8) @(posedge hclk);
      chk(32'(n_stack - s0), 32'd2, "two pending serviced");
      chk({24'h0, acks}, 32'h24, "both acknowledged");
      hold_mask <= 1'b1;
      irq_req <= 8'h01;
      repeat (4) @(posedge hclk);
      step(4'h1);
      repeat (4) @(posedge hclk);
      chk(32'(n_stack - s0), 32'd2, "masked request taken");
      step(4'h8);
      repeat (4) @(posedge hclk);
      chk({31'h0, last_pc}, 32'h0, "software interrupt pc");
      chk(32'(n_stack - s0), 32'd3, "software interrupt under mask");
      repeat (6) @(posedge hclk);
      chk(32'(n_stack - s0), 32'd3, "masked request at return");
      hold_mask <= 1'b0;
      step(4'h1);
      repeat (6) @(posedge hclk);
      chk({31'h0, last_pc}, 32'h1, "hardware interrupt pc");
      irq_en <= 8'hfd;
      irq_req <= 8'h02;
      repeat (4) @(posedge hclk);
      step(4'h1);
      repeat (4) @(posedge hclk);
      chk(32'(n_stack - s0), 32'd4, "disabled request taken");
      irq_req <= 8'h00;
      irq_en <= 8'hff;
      step(4'h4);
      repeat (2) @(posedge hclk);
      chk({29'h0, cpu_clk_en, periph_clk_en, wdog_run}, 32'h3, "wait clocks");
      irq_req <= 8'h08;
      repeat (12) @(posedge hclk);
      chk(32'(n_stack - s0), 32'd5, "wake from wait");
      chk({31'h0, cpu_clk_en}, 32'h1, "cpu clock back");
      svc_len <= 8'd80;
      two_step_armed <= 1'b1;
      step(4'h4);
      break_req <= 1'b1;
      repeat (8) @(posedge hclk);
      rd_chk(8'h00, 32'h02, "break wait set");
      chk({29'h0, break_mode, flag_clear_allow, second_step_allow}, 32'h4, "break protection");
      wr(8'h08, 32'h80);
      repeat (2) @(posedge hclk);
      chk({31'h0, flag_clear_allow}, 32'h1, "clear enable in break");
      wr(8'h00, 32'h00);
      rd_chk(8'h00, 32'h00, "break wait write zero");
      wr(8'h08, 32'h00);
      break_req <= 1'b0;
      repeat (70) @(posedge hclk);
      chk({29'h0, break_mode, flag_clear_allow, second_step_allow}, 32'h3, "after break");
      two_step_armed <= 1'b0;
      repeat (80) @(posedge hclk);
      svc_len <= 8'h03;
      for (int ss = 0; ss < 2; ss++) begin
         wr(8'h0c, 32'(ss));
         step(4'h2);
         repeat (2) @(posedge hclk);
         chk({31'h0, osc_clk_en}, 32'h0, "stop gates clocks");
         irq_req <= 8'h10;
         n = 0;
         while (stack_req !== 1'b1 && n < 300) begin
            @(posedge hclk);
            n++;
         end
         chk({31'h0, n >= (ss ? SHORT : LONG) && n <= (ss ? SHORT : LONG) + 10}, 32'h1, "stop recovery");
         repeat (8) @(posedge hclk);
      end
      wr(8'h0c, 32'h00);
      s0 = n_stack;
      irq_req <= 8'h01;
      repeat (4) @(posedge hclk);
      step(4'h1);
      hresetn <= 1'b0;
      irq_req <= 8'h00;
      repeat (2) @(posedge hclk);
      chk({29'h0, vec_sel, stack_req}, 32'h0, "reset over interrupt");
      hresetn <= 1'b1;
      repeat (6) @(posedge hclk);
      chk(32'(n_stack - s0), 32'd0, "no stacking after reset");
      rd_chk(8'h04, 32'h80, "reset source after reset");
      end_of_test();
   end
endmodule
bind exlp_core exlp_core_sva #(.N_IRQ(N_IRQ)) i_exlp_core_sva (.hclk(hclk), .hresetn(hresetn),
   .hreadyout(hreadyout), .hresp(hresp), .irq_ack(irq_ack), .soft_int_exec(soft_int_exec), .wait_exec(wait_exec),
   .stop_exec(stop_exec), .int_return_exec(int_return_exec), .break_req(break_req), .stack_req(stack_req),
   .stack_pc_minus1(stack_pc_minus1), .stack_index_high(stack_index_high), .set_mask(set_mask),
   .clear_mask(clear_mask), .vec_sel(vec_sel), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
   .osc_clk_en(osc_clk_en), .break_mode(break_mode), .flag_clear_allow(flag_clear_allow));
